//--- core/net_feature_defs.vh
// Constants for the network device feature and configuration register bank.
// Assumes inclusion by the bank module only; holds definitions and nothing else.
`ifndef NET_FEATURE_DEFS_VH
`define NET_FEATURE_DEFS_VH

// Feature bit positions.
`define F_DEV_CSUM        0
`define F_DRV_CSUM        1
`define F_CTRL_OFFLOADS   2
`define F_MAX_PAYLOAD     3
`define F_STATION_ADDR    5
`define F_LEGACY_GSO      6 // [R12]
`define F_DRV_TSO4        7 // [R5]
`define F_DRV_TSO6        8
`define F_DRV_ECN         9
`define F_DRV_UFO         10
`define F_DEV_TSO4        11
`define F_DEV_TSO6        12
`define F_DEV_ECN         13
`define F_DEV_UFO         14
`define F_MERGED_RX       15
`define F_STATUS          16
`define F_CONTROL_QUEUE   17
`define F_CTRL_RX_MODE    18
`define F_CTRL_VLAN       19
`define F_ANNOUNCE        21
`define F_MULTIQUEUE      22
`define F_CTRL_ADDR       23
`define F_LEGACY_RSC4     41
`define F_LEGACY_RSC6     42
`define F_DUP_ACK         61 // [R7]
`define F_STANDBY         62 // [R7]

// Status field bits, given as bit positions of weight 1 and 2.
`define S_LINK_UP         0
`define S_ANNOUNCE        1

// Register byte offsets.
`define A_DEVICE_TYPE     6'h00
`define A_OFFER_LO        6'h04
`define A_OFFER_HI        6'h08
`define A_ACCEPT_LO       6'h0c
`define A_ACCEPT_HI       6'h10
`define A_CFG_ADDR_LO     6'h14
`define A_CFG_ADDR_HI     6'h18
`define A_CFG_QP_PAYLOAD  6'h1c
`define A_QUEUE_MAP       6'h20
`define A_QUEUE_SELECT    6'h24
`define A_QUEUE_INFO      6'h28

// Limits on advertised values.
`define QP_MIN            16'h0001
`define QP_MAX            16'h8000
`define PAYLOAD_MIN       16'h0044

// Queue kinds in the lookup answer.
`define QK_RX             2'h0
`define QK_TX             2'h1
`define QK_CTRL           2'h2
`define QK_NONE           2'h3

`endif

//--- core/net_feature_config.v
// Feature negotiation, queue numbering and read-only configuration area of a
// paravirtual network device, reached over an Avalon-MM slave with waitrequest.
// Assumes the transport in front of it maps driver accesses onto this bus.
//
// Functional notes
// [R1] A read-only register exposes the device-type code identifying a network interface.
// [R2] Queue pair count is one unless multiqueue accepted, then the configured maximum.
// [R3] Receive queue k uses 2(k-1), transmit 2(k-1)+1, control 2N when enabled.
// [R4] Checksum, offload control, payload report and address flags sit at bits 0,1,2,3,5.
// [R5] Segmentation flags: driver side bits 7-10, device side bits 11-14.
// [R6] Merged buffers 15, status 16, control queue 17, then bits 18,19,21,22,23.
// [R7] Bit 61 flags duplicate-ack coalescing, bit 62 flags standby capability.
// [R8] Driver offload flags need driver checksum; congestion flag needs a driver TCP flag.
// [R9] Device offload flags need device checksum; congestion flag needs a device TCP flag.
// [R10] Control-queue dependent flags are accepted only with the control-queue flag.
// [R11] Duplicate-ack coalescing accepted only with a device TCP segmentation flag.
// [R12] Legacy flags recognised at bits 6, 41 and 42.
// [R13] Config area: address, then status, queue pair limit, payload, little endian, read only.
// [R14] Address always present; status field reads only when status feature offered.
// [R15] Status reports link up in weight 1, announce request in weight 2.
// [R16] Queue pair limit present only when multiqueue offered.
// [R17] Payload field present only when payload reporting offered; advertises largest payload.
// [R18] Driver treats the payload field as the upper frame payload limit.
// [R19] Queue pair limit is held between 1 and 0x8000 inclusive.
// [R20] Payload field is held between 68 and 65535 inclusive.
// [R21] Payload field is fixed after reset and never changes.
// [R22] Offered set is a constant; accepted subset drops bits lacking prerequisites.
`timescale 1ns/100ps
`include "net_feature_defs.vh"

module net_feature_config #(
	parameter [63:0] OFFERED_FEATURES = 64'h4000_0000_0071_7fff,
	// The device-type default is arbitrary.
	parameter [15:0] DEVICE_TYPE      = 16'h00a5,
	parameter [47:0] STATION_ADDRESS  = 48'h02_00_00_00_00_01,
	parameter [15:0] QUEUE_PAIRS      = 16'h0004,
	parameter [15:0] MAX_PAYLOAD      = 16'h05dc
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// Avalon-MM slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// Link state from the network side
	input  wire        link_up_in,
	input  wire        announce_in,
	// Negotiated results
	output reg  [63:0] accepted_features,
	output reg  [15:0] queue_pairs,
	output reg         control_queue_on
);

	// Queue pair limit is kept constant via parameters; the clamp makes out-of-range settings safe.
	function [15:0] clamp_qp;
		input [15:0] v;
		begin
			if (v < `QP_MIN)
				clamp_qp = `QP_MIN;
			else if (v > `QP_MAX)
				clamp_qp = `QP_MAX;
			else
				clamp_qp = v;
		end
	endfunction

	// Drops every bit whose prerequisites are not present in the same vector.
	function [63:0] prune;
		input [63:0] f;
		reg   [63:0] r;
		begin
			r = f;
			r[`F_DRV_TSO4] = f[`F_DRV_TSO4] & f[`F_DRV_CSUM]; // [R8]
			r[`F_DRV_TSO6] = f[`F_DRV_TSO6] & f[`F_DRV_CSUM]; // [R8]
			r[`F_DRV_UFO]  = f[`F_DRV_UFO] & f[`F_DRV_CSUM]; // [R8]
			r[`F_DRV_ECN]  = f[`F_DRV_ECN] & (r[`F_DRV_TSO4] | r[`F_DRV_TSO6]); // [R8]
			r[`F_DEV_TSO4] = f[`F_DEV_TSO4] & f[`F_DEV_CSUM]; // [R9]
			r[`F_DEV_TSO6] = f[`F_DEV_TSO6] & f[`F_DEV_CSUM]; // [R9]
			r[`F_DEV_UFO]  = f[`F_DEV_UFO] & f[`F_DEV_CSUM]; // [R9]
			r[`F_DEV_ECN]  = f[`F_DEV_ECN] & (r[`F_DEV_TSO4] | r[`F_DEV_TSO6]); // [R9]
			r[`F_CTRL_RX_MODE] = f[`F_CTRL_RX_MODE] & f[`F_CONTROL_QUEUE]; // [R10]
			r[`F_CTRL_VLAN]    = f[`F_CTRL_VLAN] & f[`F_CONTROL_QUEUE]; // [R10]
			r[`F_ANNOUNCE]     = f[`F_ANNOUNCE] & f[`F_CONTROL_QUEUE]; // [R10]
			r[`F_MULTIQUEUE]   = f[`F_MULTIQUEUE] & f[`F_CONTROL_QUEUE]; // [R10]
			r[`F_CTRL_ADDR]    = f[`F_CTRL_ADDR] & f[`F_CONTROL_QUEUE]; // [R10]
			r[`F_DUP_ACK] = f[`F_DUP_ACK] & (r[`F_DEV_TSO4] | r[`F_DEV_TSO6]); // [R11]
			prune = r;
		end
	endfunction

	// Offered set is fixed; the pruned form is what software sees as offered.
	wire [63:0] offered = prune(OFFERED_FEATURES); // [R22]
	// Bit positions for [R4] [R5] [R6] [R7] [R12] are the `define map used throughout.
	wire        off_status = offered[`F_STATUS]; // [R6]
	wire        off_mq     = offered[`F_MULTIQUEUE]; // [R6]
	wire        off_pay    = offered[`F_MAX_PAYLOAD]; // [R4]

	// Payload clamp is evaluated on a constant, so the field cannot change at run time.
	wire [15:0] payload_fixed = (MAX_PAYLOAD < `PAYLOAD_MIN) ? `PAYLOAD_MIN : MAX_PAYLOAD; // [R20] [R21]
	wire [15:0] qp_limit = clamp_qp(QUEUE_PAIRS); // [R19]

	// Link inputs come from another domain and are synchronised first.
	reg  [1:0]  link_sync_reg;
	reg  [1:0]  ann_sync_reg;
	reg  [15:0] status_reg;

	// Accepted feature staging and queue lookup.
	reg  [63:0] accept_stage_reg;
	reg  [15:0] queue_select_reg;
	reg         read_done_reg;

	wire [63:0] accept_pruned = prune(accept_stage_reg & offered); // [R22]

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			link_sync_reg <= 2'h0;
			ann_sync_reg  <= 2'h0;
			status_reg    <= 16'h0000;
		end else begin
			link_sync_reg <= {link_sync_reg[0], link_up_in};
			ann_sync_reg  <= {ann_sync_reg[0], announce_in};
			status_reg    <= 16'h0000;
			status_reg[`S_LINK_UP]  <= link_sync_reg[1]; // [R15]
			status_reg[`S_ANNOUNCE] <= ann_sync_reg[1]; // [R15]
		end
	end

	// Writes complete without wait; reads take one wait state so data come from flops.
	assign avs_waitrequest = avs_read & ~read_done_reg;

	wire wr_en = avs_write;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer      i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// Only the low half of the merged word is kept for the 16-bit select.
	wire [31:0] sel_merged = merge({16'h0, queue_select_reg}, avs_writedata, avs_byteenable);

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			accept_stage_reg  <= 64'h0;
			queue_select_reg  <= 16'h0;
			accepted_features <= 64'h0;
			queue_pairs       <= 16'h0001;
			control_queue_on  <= 1'b0;
		end else begin
			if (wr_en) begin
				case (avs_address)
				`A_ACCEPT_LO:
					accept_stage_reg[31:0] <= merge(accept_stage_reg[31:0], avs_writedata,
						avs_byteenable);
				`A_ACCEPT_HI:
					accept_stage_reg[63:32] <= merge(accept_stage_reg[63:32], avs_writedata,
						avs_byteenable);
				`A_QUEUE_SELECT:
					queue_select_reg <= sel_merged[15:0];
				default: ;
				endcase
			end
			accepted_features <= accept_pruned; // [R22]
			queue_pairs <= accept_pruned[`F_MULTIQUEUE] ? qp_limit : 16'h0001; // [R2]
			control_queue_on <= accept_pruned[`F_CONTROL_QUEUE]; // [R3]
		end
	end

	// Queue index lookup for the selected index.
	reg  [1:0]  q_kind;
	reg  [15:0] q_pair;
	wire [16:0] ctrl_index = {queue_pairs, 1'b0}; // [R3]
	always @* begin
		q_kind = `QK_NONE;
		q_pair = 16'h0;
		if ({1'b0, queue_select_reg} < ctrl_index) begin
			q_kind = queue_select_reg[0] ? `QK_TX : `QK_RX; // [R3]
			q_pair = {1'b0, queue_select_reg[15:1]} + 16'h0001; // [R3]
		end else if ({1'b0, queue_select_reg} == ctrl_index && control_queue_on) begin
			q_kind = `QK_CTRL; // [R3]
		end
	end

	// Read mux; fields not present read as zero.
	reg [31:0] rd_mux;
	always @* begin
		case (avs_address)
		`A_DEVICE_TYPE:    rd_mux = {16'h0, DEVICE_TYPE}; // [R1]
		`A_OFFER_LO:       rd_mux = offered[31:0];
		`A_OFFER_HI:       rd_mux = offered[63:32];
		`A_ACCEPT_LO:      rd_mux = accepted_features[31:0];
		`A_ACCEPT_HI:      rd_mux = accepted_features[63:32];
		// Little-endian packing: address byte 0 in the low lane. [R13] [R14]
		`A_CFG_ADDR_LO:    rd_mux = {STATION_ADDRESS[23:16], STATION_ADDRESS[31:24],
					STATION_ADDRESS[39:32], STATION_ADDRESS[47:40]};
		`A_CFG_ADDR_HI:    rd_mux = {off_status ? status_reg : 16'h0, // [R14] [R13]
					STATION_ADDRESS[7:0], STATION_ADDRESS[15:8]};
		`A_CFG_QP_PAYLOAD: rd_mux = {off_pay ? payload_fixed : 16'h0, // [R17]
					off_mq ? qp_limit : 16'h0}; // [R16]
		`A_QUEUE_MAP:      rd_mux = {15'h0, control_queue_on, queue_pairs};
		`A_QUEUE_SELECT:   rd_mux = {16'h0, queue_select_reg};
		`A_QUEUE_INFO:     rd_mux = {14'h0, q_kind, q_pair};
		default:           rd_mux = 32'h0;
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			avs_readdata  <= 32'h0;
			read_done_reg <= 1'b0;
		end else begin
			read_done_reg <= avs_read & ~read_done_reg;
			if (avs_read & ~read_done_reg)
				avs_readdata <= rd_mux;
		end
	end

endmodule

//--- tb/nfc_asserts.sv
// Concurrent checks on the feature bank ports.
// Bound into every bank instance; sees its ports only.
`timescale 1ns/100ps
module nfc_asserts #(
	parameter [63:0] OFFERED_FEATURES = 64'h0,
	parameter [15:0] QUEUE_PAIRS      = 16'h0001
) (
	// Clock, reset and bus handshake
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// Negotiated results
	input wire logic [63:0] accepted_features,
	input wire logic [15:0] queue_pairs,
	input wire logic        control_queue_on
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire [63:0] a = accepted_features;

	AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
		else $error("write was stalled");
	AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait state wrong");
	AST_IDLE: assert property (!avs_read |-> !avs_waitrequest)
		else $error("wait without read");
	AST_SUBSET: assert property ((a & ~OFFERED_FEATURES) == 64'h0)
		else $error("accepted bit not offered");
	AST_DRV: assert property (|a[10:7] |-> a[1] && (!a[9] || a[7] || a[8]))
		else $error("driver offload without prerequisite");
	AST_DEV: assert property (|a[14:11] |-> a[0] && (!a[13] || a[11] || a[12]))
		else $error("device offload without prerequisite");
	AST_CQ: assert property (|{a[23:21], a[19:18]} |-> a[17])
		else $error("control flag without control queue");
	AST_DUP: assert property (a[61] |-> a[11] || a[12])
		else $error("coalescing without device segmentation");
	// The derived outputs register on the same edge as the set, so they match it in every cycle.
	AST_QP: assert property ($stable(a)[*2] |-> queue_pairs == (a[22] ? QUEUE_PAIRS : 16'h0001))
		else $error("queue pair count wrong");
	AST_CQON: assert property ($stable(a)[*2] |-> control_queue_on == a[17])
		else $error("control queue flag wrong");
endmodule

bind net_feature_config nfc_asserts #(
	.OFFERED_FEATURES(OFFERED_FEATURES),
	.QUEUE_PAIRS(QUEUE_PAIRS)
) nfc_asserts_i (
	.sys_clk(sys_clk),
	.rst(rst),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.accepted_features(accepted_features),
	.queue_pairs(queue_pairs),
	.control_queue_on(control_queue_on)
);

//--- tb/tb_top.sv
// Self-checking bench for the feature and configuration bank.
// Assumes one read wait state; waits are cut only by the watchdog.
`timescale 1ns/100ps
module tb_top;
	localparam logic [63:0] OFF = 64'h6000_0600_00ef_ff6f;
	logic        sys_clk;
	logic        rst;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	logic        link_up_in;
	logic        announce_in;
	wire  [63:0] accepted_features;
	wire  [15:0] queue_pairs;
	wire         control_queue_on;
	int          num_errors;
	int          cmp_count;
	int          i;
	logic [31:0] lo;
	logic [31:0] hi;
	logic [31:0] d;
	logic [3:0]  be;
	logic [63:0] x;
	logic [63:0] e;
	logic [63:0] exp_q[$];

	// Device type and address values are arbitrary.
	net_feature_config #(.OFFERED_FEATURES(OFF), .DEVICE_TYPE(16'h005a),
		.STATION_ADDRESS(48'h02_11_22_22_11_02), .QUEUE_PAIRS(16'h0004),
		.MAX_PAYLOAD(16'h05dc)) net_feature_config_i (.sys_clk(sys_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.link_up_in(link_up_in), .announce_in(announce_in),
		.accepted_features(accepted_features), .queue_pairs(queue_pairs),
		.control_queue_on(control_queue_on));

	task automatic chk(input string n, input logic [63:0] ex, input logic [63:0] got);
		cmp_count++;
		if (got !== ex) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, ex, got);
		end
	endtask

	function automatic logic [63:0] prune(input logic [63:0] f);
		f[8:7] &= {2{f[1]}};
		f[10] &= f[1];
		f[9] &= f[7] | f[8];
		f[12:11] &= {2{f[0]}};
		f[14] &= f[0];
		f[13] &= f[11] | f[12];
		f[23:18] &= {6{f[17]}};
		f[61] &= f[11] | f[12];
		return f;
	endfunction

	// The request stands until waitrequest is seen low; an idle edge follows.
	task automatic bus(input logic r, input logic [5:0] a, input logic [31:0] dt,
		input logic [3:0] b);
		avs_read <= r;
		avs_write <= !r;
		avs_address <= a;
		avs_writedata <= dt;
		avs_byteenable <= b;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] v,
		input logic [31:0] m = 32'hffff_ffff);
		exp_q.push_back({m, v & m});
		bus(1'b1, a, 32'h0, 4'hf);
	endtask

	task automatic scan(input int n, input logic c, input int lim);
		for (int k = 0; k < lim; k++) begin
			bus(1'b0, 6'h24, k, 4'hf);
			if (k < 2 * n)
				rd(6'h28, {14'h0, k[0] ? 2'h1 : 2'h0, 16'(k / 2 + 1)});
			else
				rd(6'h28, {14'h0, (k == 2 * n && c) ? 2'h2 : 2'h3, 16'h0}, 32'h3_0000);
		end
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			e = exp_q.pop_front();
			chk("readdata", e[31:0], avs_readdata & e[63:32]);
		end
	end

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 6'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		link_up_in = 1'b0;
		announce_in = 1'b0;
		void'($urandom(65792));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(6'h00, 32'h5a, 32'hffff);
		rd(6'h04, OFF[31:0]);
		rd(6'h08, OFF[63:32]);
		bus(1'b0, 6'h04, 32'h0, 4'hf);
		rd(6'h04, OFF[31:0]);
		rd(6'h14, 32'h2222_1102);
		rd(6'h1c, 32'h05dc_0004);
		rd(6'h2c, 32'h0);
		for (i = 0; i < 4; i++) begin
			{announce_in, link_up_in} <= i[1:0];
			repeat (4) @(posedge sys_clk);
			rd(6'h18, {14'h0, i[1:0], 16'h0211});
		end
		// Random sets, then a partial-lane rewrite of the low word.
		for (i = 0; i < 16; i++) begin
			lo = $urandom;
			hi = $urandom;
			d = $urandom;
			be = 4'($urandom);
			bus(1'b0, 6'h0c, lo, 4'hf);
			bus(1'b0, 6'h10, hi, 4'hf);
			bus(1'b0, 6'h0c, d, be);
			for (int j = 0; j < 4; j++)
				if (be[j])
					lo[8*j+:8] = d[8*j+:8];
			x = prune({hi, lo} & OFF);
			repeat (2) @(posedge sys_clk);
			chk("accepted", x, accepted_features);
			chk("pairs", x[22] ? 64'h4 : 64'h1, {48'h0, queue_pairs});
			chk("control", {63'h0, x[17]}, {63'h0, control_queue_on});
			rd(6'h0c, x[31:0]);
			rd(6'h10, x[63:32]);
		end
		bus(1'b0, 6'h10, 32'hffff_ffff, 4'hf);
		bus(1'b0, 6'h0c, 32'hffff_ffff, 4'hf);
		scan(4, 1'b1, 10);
		bus(1'b0, 6'h0c, 32'hffbf_ffff, 4'hf);
		scan(1, 1'b1, 4);
		bus(1'b0, 6'h0c, 32'hffbd_ffff, 4'hf);
		scan(1, 1'b0, 3);
		rd(6'h1c, 32'h05dc_0004);
		stop_test();
	end
endmodule
